/* File: core/scr_pkg.sv */
// Constants for the subroutine call/return sequencer.
// Assumes a byte-addressed memory of 16-bit words behind a simple request/ack port.
package scr_pkg;
    // =========================================
    // Register numbering and widths
    localparam int unsigned WORD_W = 16;
    localparam logic [2:0] SP_IDX = 3'h6;
    localparam logic [2:0] PC_IDX = 3'h7;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    // =========================================
    // Operation codes on the command port
    localparam logic [1:0] OP_CALL = 2'h0;
    localparam logic [1:0] OP_RETURN = 2'h1;
    localparam logic [1:0] OP_JUMP = 2'h2;
    localparam logic [1:0] OP_ARG_FETCH = 2'h3;
    // =========================================
    // Sequencer states, Gray along call and return paths except ST_LINK back to ST_IDLE
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PUSH = 3'h1,
        ST_LINK = 3'h3,
        ST_POP = 3'h2,
        ST_ARG = 3'h6,
        ST_DONE = 3'h7
    } scr_state_t;
endpackage

/* File: core/scr_sequencer.sv */
// Subroutine call, return, jump and linkage-argument fetch sequencer.
// Assumes memory answers each request with mem_ack_i, any number of cycles later.
// Function
// - Call first pushes linkage register onto hardware stack, predecrement style.
// - Call then loads linkage register with the current program counter.
// - Call finally loads program counter with the entry address.
// - Return first copies the named register into the program counter.
// - Return then pops the stack top into the named register.
// - Autoincrement argument fetch advances linkage register to next word.
// - Plain jump changes program counter only, no stack write or link.
// - Hardware stack is handled in whole words at even addresses.
// - Stack grows toward lower addresses, shrinks toward higher ones.
`timescale 1ns/1ps
module scr_sequencer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [2:0] cmd_reg_i,
    input wire logic [15:0] cmd_target_i,
    output logic cmd_busy_o,
    output logic cmd_done_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    output logic [15:0] pc_o,
    output logic [15:0] sp_o,
    output logic [15:0] arg_data_o
);
    // =========================================
    // Register file (R0..R5 general, SP and PC kept apart)
    logic [15:0] gpr_q [0:5];
    logic [15:0] pc_q;
    logic [15:0] sp_q;
    scr_pkg::scr_state_t state_q;
    logic [2:0] reg_q;
    logic [15:0] target_q;
    logic busy_q;
    logic done_q;
    logic req_q;
    logic we_q;
    logic [15:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] arg_q;

    function automatic logic [15:0] read_reg(input logic [2:0] idx, input logic [15:0] pc,
                                            input logic [15:0] sp, input logic [15:0] g0,
                                            input logic [15:0] g1, input logic [15:0] g2,
                                            input logic [15:0] g3, input logic [15:0] g4,
                                            input logic [15:0] g5);
        logic [15:0] r;
        r = g0;
        case (idx)
            3'h1: r = g1;
            3'h2: r = g2;
            3'h3: r = g3;
            3'h4: r = g4;
            3'h5: r = g5;
            scr_pkg::SP_IDX: r = sp;
            scr_pkg::PC_IDX: r = pc;
            default: r = g0;
        endcase
        return r;
    endfunction

    wire [15:0] cmd_reg_val = read_reg(cmd_valid_i ? cmd_reg_i : reg_q, pc_q, sp_q,
        gpr_q[0], gpr_q[1], gpr_q[2], gpr_q[3], gpr_q[4], gpr_q[5]);
    wire accept = cmd_valid_i && !busy_q;
    wire ack_seen = req_q && mem_ack_i;
    wire [15:0] sp_dec = sp_q - scr_pkg::WORD_STEP;
    wire [15:0] sp_inc = sp_q + scr_pkg::WORD_STEP;
    // Linkage register value as held now, read by the argument fetch path
    wire [15:0] link_val = read_reg(reg_q, pc_q, sp_q,
        gpr_q[0], gpr_q[1], gpr_q[2], gpr_q[3], gpr_q[4], gpr_q[5]);

    // =========================================
    // General registers written from one place
    logic wr_en;
    logic [2:0] wr_idx;
    logic [15:0] wr_val;
    always_comb begin
        wr_en = 1'b0;
        wr_idx = reg_q;
        wr_val = 16'h0000;
        if (state_q == scr_pkg::ST_LINK) begin
            wr_en = 1'b1;
            wr_val = pc_q;
        end else if (state_q == scr_pkg::ST_POP && ack_seen) begin
            wr_en = 1'b1;
            wr_val = mem_rdata_i;
        end else if (state_q == scr_pkg::ST_ARG && ack_seen) begin
            wr_en = 1'b1;
            wr_val = link_val + scr_pkg::WORD_STEP;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_gpr
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    gpr_q[gi] <= 16'h0000;
                end else if (wr_en && wr_idx == 3'(gi)) begin
                    gpr_q[gi] <= wr_val;
                end
            end
        end
    endgenerate

    // =========================================
    // Sequencer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= scr_pkg::ST_IDLE;
            pc_q <= scr_pkg::PC_RESET;
            sp_q <= scr_pkg::SP_RESET;
            reg_q <= 3'h0;
            target_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            arg_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                scr_pkg::ST_IDLE: begin
                    if (accept) begin
                        reg_q <= cmd_reg_i;
                        target_q <= cmd_target_i;
                        case (cmd_op_i)
                            scr_pkg::OP_CALL: begin
                                busy_q <= 1'b1;
                                sp_q <= {sp_dec[15:1], 1'b0};
                                addr_q <= {sp_dec[15:1], 1'b0};
                                wdata_q <= cmd_reg_val;
                                we_q <= 1'b1;
                                req_q <= 1'b1;
                                state_q <= scr_pkg::ST_PUSH;
                            end
                            scr_pkg::OP_RETURN: begin
                                busy_q <= 1'b1;
                                pc_q <= cmd_reg_val;
                                addr_q <= {sp_q[15:1], 1'b0};
                                we_q <= 1'b0;
                                req_q <= 1'b1;
                                state_q <= scr_pkg::ST_POP;
                            end
                            scr_pkg::OP_JUMP: begin
                                pc_q <= cmd_target_i;
                                done_q <= 1'b1;
                            end
                            default: begin
                                busy_q <= 1'b1;
                                addr_q <= cmd_reg_val;
                                we_q <= 1'b0;
                                req_q <= 1'b1;
                                state_q <= scr_pkg::ST_ARG;
                            end
                        endcase
                    end
                end
                scr_pkg::ST_PUSH: begin
                    if (ack_seen) begin
                        req_q <= 1'b0;
                        we_q <= 1'b0;
                        state_q <= scr_pkg::ST_LINK;
                    end
                end
                scr_pkg::ST_LINK: begin
                    // Link gets return address, then jump
                    if (reg_q == scr_pkg::SP_IDX) begin
                        sp_q <= pc_q;
                    end
                    pc_q <= target_q;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= scr_pkg::ST_IDLE;
                end
                scr_pkg::ST_POP: begin
                    if (ack_seen) begin
                        // Stack top to named register, then step up unless the named register is SP
                        req_q <= 1'b0;
                        sp_q <= (reg_q == scr_pkg::SP_IDX) ? mem_rdata_i : sp_inc;
                        if (reg_q == scr_pkg::PC_IDX) begin
                            pc_q <= mem_rdata_i;
                        end
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= scr_pkg::ST_IDLE;
                    end
                end
                scr_pkg::ST_ARG: begin
                    if (ack_seen) begin
                        req_q <= 1'b0;
                        arg_q <= mem_rdata_i;
                        if (reg_q == scr_pkg::SP_IDX) begin
                            sp_q <= sp_inc;
                        end else if (reg_q == scr_pkg::PC_IDX) begin
                            pc_q <= pc_q + scr_pkg::WORD_STEP;
                        end
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= scr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= scr_pkg::ST_IDLE;
                    busy_q <= 1'b0;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    assign cmd_busy_o = busy_q;
    assign cmd_done_o = done_q;
    assign mem_req_o = req_q;
    assign mem_we_o = we_q;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = wdata_q;
    assign pc_o = pc_q;
    assign sp_o = sp_q;
    assign arg_data_o = arg_q;

    // =========================================
    // Checks
    sequence s_call_start;
        accept && cmd_op_i == scr_pkg::OP_CALL;
    endsequence

    a_call_push_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_call_start |=> mem_req_o && mem_we_o && mem_addr_o == $past(sp_q) - 16'h0002)
        else $error("call did not push first");
    a_call_link_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == scr_pkg::ST_LINK && reg_q < 3'h6 |=> gpr_q[$past(reg_q)] == $past(pc_q))
        else $error("linkage not loaded with pc");
    a_call_jump_target: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == scr_pkg::ST_LINK |=> pc_o == $past(target_q) && cmd_done_o)
        else $error("call did not reach entry");
    a_ret_pc_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
        accept && cmd_op_i == scr_pkg::OP_RETURN |=> pc_o == $past(cmd_reg_val))
        else $error("return pc copy wrong");
    a_ret_pop_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == scr_pkg::ST_POP && ack_seen && reg_q == scr_pkg::PC_IDX
        |=> pc_o == $past(mem_rdata_i))
        else $error("return pop wrong");
    a_arg_advance: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == scr_pkg::ST_ARG && ack_seen && reg_q < 3'h6
        |=> gpr_q[$past(reg_q)] == $past(link_val) + 16'h0002)
        else $error("argument register not advanced");
    a_jump_no_stack: assert property (@(posedge core_clk_i) disable iff (rst_i)
        accept && cmd_op_i == scr_pkg::OP_JUMP |=> !mem_req_o && $stable(sp_o) && cmd_done_o)
        else $error("jump touched stack");
    a_stack_even: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mem_req_o && state_q inside {scr_pkg::ST_PUSH, scr_pkg::ST_POP} |-> !mem_addr_o[0])
        else $error("odd stack address");
    a_pop_increment: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == scr_pkg::ST_POP && ack_seen && reg_q != scr_pkg::SP_IDX
        |=> sp_o == $past(sp_q) + 16'h0002)
        else $error("pop did not increment sp");
endmodule

/* File: bench/scr_stack_mem.sv */
// Behavioural word memory that holds the hardware stack and argument words.
// Assumes the sequencer holds its request level until it samples the ack.
`timescale 1ns/1ps
module scr_stack_mem (
    input wire logic core_clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    // =========================================
    // Storage and bench-visible counters
    logic [15:0] mem [0:32767];
    int lat = 0;
    int cnt = 0;
    int n_wr = 0;
    int n_rd = 0;
    int n_odd = 0;
    logic [15:0] last_waddr = 16'h0000;
    logic [15:0] last_wdata = 16'h0000;
    initial begin
        mem_ack_o = 1'b0;
        mem_rdata_o = 16'h0000;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'(i * 2) ^ 16'hA5A5;
        end
    end
    // =========================================
    // Request service, ack after lat wait cycles
    always @(posedge core_clk_i) begin
        // Read data inverts on every edge except one that loads a read word, so the old word shows again every second edge
        mem_rdata_o <= ~mem_rdata_o;
        mem_ack_o <= 1'b0;
        if (mem_req_i && !mem_ack_o) begin
            if (cnt >= lat) begin
                mem_ack_o <= 1'b1;
                cnt <= 0;
                if (mem_addr_i[0]) n_odd <= n_odd + 1;
                if (mem_we_i) begin
                    mem[mem_addr_i[15:1]] <= mem_wdata_i;
                    last_waddr <= mem_addr_i;
                    last_wdata <= mem_wdata_i;
                    n_wr <= n_wr + 1;
                end else begin
                    mem_rdata_o <= mem[mem_addr_i[15:1]];
                    n_rd <= n_rd + 1;
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

/* File: bench/scr_sequencer_test.sv */
// Self-checking bench for the call/return sequencer against a stack memory.
// Assumes reset values of zero for pc, stack and general registers.
`timescale 1ns/1ps
module scr_sequencer_test;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [2:0] cmd_reg_i = 3'h0;
    logic [15:0] cmd_target_i = 16'h0000;
    logic cmd_busy_o, cmd_done_o, mem_req_o, mem_we_o, mem_ack_i;
    logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, pc_o, sp_o, arg_data_o;
    int n_fail = 0;
    int checks_done = 0;
    int cyc;
    scr_sequencer u_scr_sequencer (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_reg_i(cmd_reg_i),
        .cmd_target_i(cmd_target_i), .cmd_busy_o(cmd_busy_o), .cmd_done_o(cmd_done_o),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .pc_o(pc_o), .sp_o(sp_o), .arg_data_o(arg_data_o));
    scr_stack_mem u_scr_stack_mem (.core_clk_i(core_clk_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    // =========================================
    // Clock, reporting and command tasks
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One command; cyc counts edges from take to the done pulse
    task automatic run(input logic [1:0] op, input logic [2:0] r, input logic [15:0] t,
                       input int lat);
        u_scr_stack_mem.lat = lat;
        @(negedge core_clk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        cmd_reg_i = r;
        cmd_target_i = t;
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        cyc = 0;
        while (cmd_done_o !== 1'b1 && cyc < 200) begin
            @(negedge core_clk_i);
            cyc++;
        end
        chk("done", {15'h0000, cmd_done_o}, 16'h0001);
    endtask
    function automatic logic [15:0] word_at(input logic [15:0] a);
        return a ^ 16'hA5A5;
    endfunction
    // =========================================
    // Scenarios
    task automatic t_jump();
        run(scr_pkg::OP_JUMP, 3'h5, 16'h0100, 0);
        chk("jump cycles", 16'(cyc), 16'h0000);
        chk("jump pc", pc_o, 16'h0100);
        chk("jump writes", 16'(u_scr_stack_mem.n_wr), 16'h0000);
        chk("jump sp", sp_o, 16'h0000);
    endtask
    task automatic t_call_first();
        run(scr_pkg::OP_CALL, 3'h5, 16'h1000, 0);
        chk("call cycles", 16'(cyc), 16'h0003);
        chk("push addr", u_scr_stack_mem.last_waddr, 16'hFFFE);
        chk("push data", u_scr_stack_mem.last_wdata, 16'h0000);
        chk("call sp", sp_o, 16'hFFFE);
        chk("call pc", pc_o, 16'h1000);
    endtask
    // Jump offered while busy must be dropped, not queued
    task automatic t_call_refuse();
        u_scr_stack_mem.lat = 2;
        @(negedge core_clk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = scr_pkg::OP_CALL;
        cmd_reg_i = 3'h5;
        cmd_target_i = 16'h2000;
        @(negedge core_clk_i);
        cmd_op_i = scr_pkg::OP_JUMP;
        cmd_target_i = 16'h7776;
        chk("busy in call", {15'h0000, cmd_busy_o}, 16'h0001);
        repeat (2) @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        cyc = 0;
        while (cmd_done_o !== 1'b1 && cyc < 200) begin
            @(negedge core_clk_i);
            cyc++;
        end
        chk("link pushed", u_scr_stack_mem.last_wdata, 16'h0100);
        chk("push addr2", u_scr_stack_mem.last_waddr, 16'hFFFC);
        chk("refused pc", pc_o, 16'h2000);
        chk("busy after call", {15'h0000, cmd_busy_o}, 16'h0000);
        @(negedge core_clk_i);
        chk("no queued jump", pc_o, 16'h2000);
    endtask
    task automatic t_args();
        run(scr_pkg::OP_ARG_FETCH, 3'h5, 16'h0000, 1);
        chk("arg cycles", 16'(cyc), 16'h0003);
        chk("arg 1", arg_data_o, word_at(16'h1000));
        run(scr_pkg::OP_ARG_FETCH, 3'h5, 16'h0000, 0);
        chk("arg 2", arg_data_o, word_at(16'h1002));
    endtask
    task automatic t_return();
        run(scr_pkg::OP_RETURN, 3'h5, 16'h0000, 0);
        chk("ret cycles", 16'(cyc), 16'h0002);
        chk("ret pc", pc_o, 16'h1004);
        chk("ret sp", sp_o, 16'hFFFE);
        run(scr_pkg::OP_ARG_FETCH, 3'h5, 16'h0000, 0);
        chk("popped link", arg_data_o, word_at(16'h0100));
    endtask
    task automatic t_pc_link();
        run(scr_pkg::OP_CALL, scr_pkg::PC_IDX, 16'h3000, 3);
        chk("pc push", u_scr_stack_mem.last_wdata, 16'h1004);
        chk("pc call", pc_o, 16'h3000);
        run(scr_pkg::OP_RETURN, scr_pkg::PC_IDX, 16'h0000, 1);
        chk("pc return", pc_o, 16'h1004);
        chk("final sp", sp_o, 16'hFFFE);
        run(scr_pkg::OP_ARG_FETCH, scr_pkg::PC_IDX, 16'h0000, 0);
        chk("pc arg", arg_data_o, word_at(16'h1004));
        chk("pc advanced", pc_o, 16'h1006);
        run(scr_pkg::OP_ARG_FETCH, scr_pkg::SP_IDX, 16'h0000, 0);
        chk("sp arg", arg_data_o, 16'h0000);
        chk("sp advanced", sp_o, 16'h0000);
        chk("odd stack", 16'(u_scr_stack_mem.n_odd), 16'h0000);
    endtask
    // =========================================
    // Main sequence and watchdog
    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk("reset pc", pc_o, 16'h0000);
        chk("reset sp", sp_o, 16'h0000);
        t_jump();
        t_call_first();
        t_call_refuse();
        t_args();
        t_return();
        t_pc_link();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_fail++;
        give_verdict();
    end
endmodule
